// file: core/lcs_clock_source_prescaler.sv
// lcs_clock_source_prescaler: lcd clock source select and 4-bit prescaler
// assumes oscillator inputs are asynchronous pins slower than clk_sys/4
//
// Notes on behaviour
// R1 - system clock divided by fixed 256 is one source, not changeable
// R2 - two-bit source select field chooses among three clock sources
// R3 - software enables the secondary oscillator before selecting it
// R4 - 31 kHz low-frequency internal oscillator is the third source
// R5 - oscillator sources keep the lcd clock running during processor sleep
// R6 - selected clock divided by 4-bit prescaler counter set by select field
// R7 - prescaler counter is never visible or writable from outside
// R8 - prescale ratios 1:1 to 1:16 chosen by the select field
// R9 - select value n divides by n plus one
// R10 - 00 system, 01 secondary crystal, 10 or 11 low-frequency oscillator
`timescale 1ns/1ns
`default_nettype none
module lcs_clock_source_prescaler #(
  parameter int unsigned SYS_DIV = lcs_pkg::SYS_DIV
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sleep_mode,
  input wire logic secondary_crystal_osc,
  input wire logic secondary_osc_enable,
  input wire logic low_freq_internal_osc,
  input wire lcs_pkg::lcs_cfg_t cfg,
  output lcs_pkg::lcs_out_t lcd_out
);
  // the free-running counter wraps at 2**SYS_DIV_W, so no other ratio can be served
  if (SYS_DIV != (1 << lcs_pkg::SYS_DIV_W))
  begin : g_bad_sys_div
    $error("system divider must equal the counter wrap");
  end

  typedef struct packed {
    logic [lcs_pkg::SYS_DIV_W-1:0] sys_cnt;
    logic [lcs_pkg::PRESCALE_W-1:0] pre_cnt;
    logic tick;
    logic level;
  } lcs_state_t;

  lcs_state_t st_reg;
  lcs_state_t st_next;
  logic sec_rise;
  logic lfo_rise;
  logic src_tick;
  logic sys_tick;

  function automatic logic pick_source(input logic [1:0] sel, input logic s, input logic c, input logic l);
    case (sel)
      lcs_pkg::SRC_SYS: pick_source = s; // [R10]
      lcs_pkg::SRC_SEC: pick_source = c; // [R10]
      default: pick_source = l; // [R4] [R10]
    endcase
  endfunction : pick_source

  lcs_edge_sync u_sec (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(secondary_crystal_osc),
    .rise(sec_rise)
  );

  lcs_edge_sync u_lfo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(low_freq_internal_osc),
    .rise(lfo_rise)
  );

  // system source stops in sleep; oscillator sources keep running
  assign sys_tick = (st_reg.sys_cnt == lcs_pkg::SYS_DIV_W'(SYS_DIV - 1)) & ~sleep_mode; // [R1] [R5]
  assign src_tick = pick_source(cfg.lcd_clock_source_select, sys_tick,
                                sec_rise & secondary_osc_enable, lfo_rise); // [R2] [R3]

  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!sleep_mode)
    begin
      st_next.sys_cnt = st_reg.sys_cnt + 1'b1; // [R1]
    end
    if (src_tick)
    begin
      if (st_reg.pre_cnt >= cfg.lcd_prescale_select)
      begin
        st_next.pre_cnt = '0; // [R6] [R9]
        st_next.tick = 1'b1; // [R8]
        st_next.level = ~st_reg.level;
      end
      else
      begin
        st_next.pre_cnt = st_reg.pre_cnt + 1'b1; // [R6]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // counter itself has no port; only tick and level leave the block
  assign lcd_out.lcd_clk_tick = st_reg.tick; // [R7]
  assign lcd_out.lcd_clk_level = st_reg.level;

  // helper: source ticks since last output tick
  logic [4:0] src_seen_reg;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      src_seen_reg <= 5'h00;
    end
    else if (st_reg.tick)
    begin
      src_seen_reg <= {4'h0, src_tick};
    end
    else if (src_tick)
    begin
      src_seen_reg <= src_seen_reg + 5'h01;
    end
  end

  property p_sys_period;
    @(posedge clk_sys) disable iff (!rstn)
    (sys_tick && !sleep_mode) |-> ##1 (!sys_tick || sleep_mode) [*8];
  endproperty
  a_sys_period: assert property (p_sys_period) else $error("system tick repeats too soon"); // [R1]

  property p_tick_follows_src;
    @(posedge clk_sys) disable iff (!rstn)
    st_reg.tick |-> $past(src_tick);
  endproperty
  a_tick_follows_src: assert property (p_tick_follows_src) else $error("output tick without source tick"); // [R2]

  property p_sec_gated;
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.lcd_clock_source_select == lcs_pkg::SRC_SEC && !secondary_osc_enable) |-> !src_tick;
  endproperty
  a_sec_gated: assert property (p_sec_gated) else $error("secondary source ticks while disabled"); // [R3]

  property p_lfo_select;
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.lcd_clock_source_select[1]) |-> (src_tick == lfo_rise);
  endproperty
  a_lfo_select: assert property (p_lfo_select) else $error("low-frequency source not routed"); // [R4] [R10]

  property p_sleep_runs;
    @(posedge clk_sys) disable iff (!rstn)
    (sleep_mode && cfg.lcd_clock_source_select[1] && lfo_rise) |-> (src_tick);
  endproperty
  a_sleep_runs: assert property (p_sleep_runs) else $error("oscillator source stopped in sleep"); // [R5]

  property p_sleep_sys_stops;
    @(posedge clk_sys) disable iff (!rstn)
    sleep_mode |-> !sys_tick ##1 $stable(st_reg.sys_cnt);
  endproperty
  a_sleep_sys_stops: assert property (p_sleep_sys_stops) else $error("system source runs in sleep"); // [R5]

  // src_seen_reg still holds the completed count in the cycle that shows the tick
  property p_ratio;
    @(posedge clk_sys) disable iff (!rstn)
    (st_reg.tick && $stable(cfg)) |-> (src_seen_reg == {1'b0, cfg.lcd_prescale_select} + 5'h01);
  endproperty
  a_ratio: assert property (p_ratio) else $error("prescale ratio wrong"); // [R6] [R8] [R9]

  property p_one_to_one;
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.lcd_prescale_select == 4'h0 && src_tick) |=> st_reg.tick;
  endproperty
  a_one_to_one: assert property (p_one_to_one) else $error("ratio 1:1 not passing clock"); // [R9]

  property p_level_toggle;
    @(posedge clk_sys) disable iff (!rstn)
    st_reg.tick |-> (st_reg.level != $past(st_reg.level));
  endproperty
  a_level_toggle: assert property (p_level_toggle) else $error("level did not toggle"); // [R6]

  // counter stepping and hold checks, then secondary-in-sleep and system routing checks
  property p_sys_count;
    @(posedge clk_sys) disable iff (!rstn)
    !sleep_mode |=> (st_reg.sys_cnt == $past(st_reg.sys_cnt) + 1'b1);
  endproperty
  a_sys_count: assert property (p_sys_count) else $error("system divider did not step"); // [R1]

  property p_pre_hold;
    @(posedge clk_sys) disable iff (!rstn)
    !src_tick |=> ($stable(st_reg.pre_cnt) && $stable(st_reg.level) && !st_reg.tick);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("prescaler moved without source tick"); // [R6]

  property p_pre_count;
    @(posedge clk_sys) disable iff (!rstn)
    (src_tick && st_reg.pre_cnt < cfg.lcd_prescale_select) |=> (st_reg.pre_cnt == $past(st_reg.pre_cnt) + 1'b1 && !st_reg.tick);
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("prescaler did not count up"); // [R6] [R8]

  property p_sec_runs;
    @(posedge clk_sys) disable iff (!rstn)
    (sleep_mode && cfg.lcd_clock_source_select == lcs_pkg::SRC_SEC && secondary_osc_enable && sec_rise) |-> src_tick;
  endproperty
  a_sec_runs: assert property (p_sec_runs) else $error("secondary source stopped in sleep"); // [R5]

  property p_sys_select;
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.lcd_clock_source_select == lcs_pkg::SRC_SYS) |-> (src_tick == sys_tick);
  endproperty
  a_sys_select: assert property (p_sys_select) else $error("system source not routed"); // [R2] [R10]

  c_sys: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_reg.tick && cfg.lcd_clock_source_select == lcs_pkg::SRC_SYS);
  c_sec: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_reg.tick && cfg.lcd_clock_source_select == lcs_pkg::SRC_SEC);
  c_lfo_sleep: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_reg.tick && sleep_mode && cfg.lcd_clock_source_select[1]);
  c_div16: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_reg.tick && cfg.lcd_prescale_select == 4'hf);
endmodule : lcs_clock_source_prescaler
`default_nettype wire

// file: pkg/lcs_pkg.sv
// lcs_pkg: constants and carrier types for the lcd clock source and prescaler
// assumes a single 100 MHz system clock domain
package lcs_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned SYS_DIV = 256;
  localparam int unsigned SYS_DIV_W = 8;
  localparam int unsigned PRESCALE_W = 4;
  localparam logic [1:0] SRC_SYS = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [3:0] PRESCALE_RST = 4'h0;
  localparam logic [1:0] SRC_RST = 2'h0;

  typedef struct packed {
    logic [1:0] lcd_clock_source_select;
    logic [3:0] lcd_prescale_select;
  } lcs_cfg_t;

  typedef struct packed {
    logic lcd_clk_tick;
    logic lcd_clk_level;
  } lcs_out_t;
endpackage : lcs_pkg

// file: core/lcs_edge_sync.sv
// lcs_edge_sync: two-flop synchroniser plus rising-edge detect for an oscillator pin
// assumes the pin is slow compared with clk_sys
`timescale 1ns/1ns
`default_nettype none
module lcs_edge_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin_in,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } lcs_sync_t;

  lcs_sync_t st_reg;
  lcs_sync_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.rise = st_reg.s2 & ~st_reg.s3;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rise = st_reg.rise;
endmodule : lcs_edge_sync
`default_nettype wire

// file: verif/test_lcd_clock_source_prescaler.sv
// test_lcd_clock_source_prescaler: self-checking bench for the lcd clock source and prescaler
// assumes lcs_pkg and the core files are compiled first; oscillator pins are driven slowly
`timescale 1ns/1ns
`default_nettype none
module test_lcd_clock_source_prescaler;
  logic clk_sys, rstn, sleep_mode, secondary_crystal_osc, secondary_osc_enable, low_freq_internal_osc;
  lcs_pkg::lcs_cfg_t cfg;
  lcs_pkg::lcs_out_t lcd_out;
  int n_mismatch, n_tests, n_tick, lat, g;
  lcs_clock_source_prescaler DUT (.clk_sys(clk_sys), .rstn(rstn), .sleep_mode(sleep_mode),
    .secondary_crystal_osc(secondary_crystal_osc), .secondary_osc_enable(secondary_osc_enable),
    .low_freq_internal_osc(low_freq_internal_osc), .cfg(cfg), .lcd_out(lcd_out));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys or negedge rstn)
    if (!rstn)
      n_tick <= 0;
    else if (lcd_out.lcd_clk_tick === 1'b1)
      n_tick <= n_tick + 1;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task complete_run;
    $display("mismatches=%0d compares=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task rst(input logic [1:0] s, input logic [3:0] p);
    @(posedge clk_sys);
    rstn <= 1'b0;
    cfg <= {s, p};
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask : rst
  // one rising edge on the chosen pin; lat is the cycle of the first tick after it
  task osc_edge(input bit sec);
    @(posedge clk_sys);
    if (sec)
      secondary_crystal_osc <= 1'b1;
    else
      low_freq_internal_osc <= 1'b1;
    lat = 0;
    for (int i = 1; i < 8; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (lcd_out.lcd_clk_tick === 1'b1 && lat == 0)
        lat = i;
    end
    @(posedge clk_sys);
    secondary_crystal_osc <= 1'b0;
    low_freq_internal_osc <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : osc_edge
  // cycles between two consecutive ticks
  task gap;
    int i;
    i = 0;
    #1;
    while (lcd_out.lcd_clk_tick !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
      i++;
      if (i > 5000)
      begin
        n_mismatch++;
        complete_run();
      end
    end
    g = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      g++;
    end while (lcd_out.lcd_clk_tick !== 1'b1 && g < 5000);
    if (g >= 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : gap
  task sc_sys;
    for (int p = 0; p < 16; p += 5)
    begin
      rst(lcs_pkg::SRC_SYS, 4'(p));
      gap();
      chk(16'(g), 16'(lcs_pkg::SYS_DIV * (p + 1)));
    end
  endtask : sc_sys
  task sc_lfo;
    for (int s = 2; s < 4; s++)
    begin
      rst(2'(s), 4'h2);
      repeat (9) osc_edge(1'b0);
      chk(16'(n_tick), 16'h3);
      chk(16'(lcd_out.lcd_clk_level), 16'h1);
    end
    rst(2'h2, 4'h0);
    osc_edge(1'b0);
    chk(16'(lat), 16'h4);
    secondary_osc_enable <= 1'b1;
    osc_edge(1'b1);
    chk(16'(n_tick), 16'h1);
  endtask : sc_lfo
  task sc_sec;
    secondary_osc_enable <= 1'b0;
    rst(lcs_pkg::SRC_SEC, 4'h0);
    repeat (2) osc_edge(1'b1);
    chk(16'(n_tick), 16'h0);
    secondary_osc_enable <= 1'b1;
    repeat (2) osc_edge(1'b1);
    chk(16'(n_tick), 16'h2);
    chk(16'(lat), 16'h4);
    osc_edge(1'b0);
    chk(16'(n_tick), 16'h2);
  endtask : sc_sec
  task sc_sleep;
    sleep_mode <= 1'b1;
    rst(lcs_pkg::SRC_SYS, 4'h0);
    repeat (700) @(posedge clk_sys);
    #1;
    chk(16'(n_tick), 16'h0);
    cfg <= {2'h2, 4'h0};
    repeat (2) osc_edge(1'b0);
    chk(16'(n_tick), 16'h2);
    cfg <= {lcs_pkg::SRC_SEC, 4'h0};
    osc_edge(1'b1);
    chk(16'(n_tick), 16'h3);
    sleep_mode <= 1'b0;
    cfg <= {lcs_pkg::SRC_SYS, 4'h0};
    gap();
    chk(16'(g), 16'(lcs_pkg::SYS_DIV));
  endtask : sc_sleep
  initial
  begin
    rstn = 1'b0;
    sleep_mode = 1'b0;
    secondary_crystal_osc = 1'b0;
    secondary_osc_enable = 1'b0;
    low_freq_internal_osc = 1'b0;
    cfg = '0;
    n_mismatch = 0;
    n_tests = 0;
    sc_sys();
    sc_lfo();
    sc_sec();
    sc_sleep();
    complete_run();
  end
endmodule : test_lcd_clock_source_prescaler
`default_nettype wire
